// file: lmbs_defs.svh
// Purpose: constants of the local memory bus sequencer
// Assumes: sys_clk stands for the oscillator input; one memory cycle = 16 clocks
// Notes: phases count sixteenths of a memory cycle
`ifndef LMBS_DEFS_SVH
`define LMBS_DEFS_SVH
`define LMBS_ADDR_W        21
`define LMBS_LAST_PHASE    4'h000F
`define LMBS_ROW_END       4'h0005
`define LMBS_COL_END       4'h0008
`define LMBS_REF_ROW_START 4'h0001
`define LMBS_REF_ROW_END   4'h0006
`define LMBS_DATA_START    4'h0008
`define LMBS_CLKB_LAG      4'h0002
`define LMBS_EXT_LSB       16
`define LMBS_CHAP_ROM_HI   5'h001F
`define LMBS_CHAP_ROM_LO   5'h0000
`endif

// file: lmbs_pkg.sv
// Purpose: types of the local memory bus sequencer
// Assumes: nothing
// Notes: whole module state is one packed struct
package lmbs_pkg;
  typedef enum logic [1:0] {LMBS_IDLE, LMBS_ACCESS, LMBS_REFRESH} lmbs_state_t;

  typedef struct packed {
    lmbs_state_t state;
    logic [3:0]  phase;
    logic [20:0] addr;
    logic        write;
    logic        wrParH;
    logic        wrParL;
    logic        codeInRam;
    logic        reqReady;
    logic        rdValid;
    logic        rdParH;
    logic        rdParL;
    logic        clkA;
    logic        clkB;
    logic        parHOut;
    logic        parHOe;
    logic        parLOut;
    logic        parLOe;
    logic        bufEnN;
    logic        bufDir;
    logic        romOeN;
    logic        colN;
    logic        rowN;
    logic        refAct;
  } lmbs_st_t;
endpackage : lmbs_pkg

// file: lmbs_sequencer.sv
// Purpose: local memory bus cycle sequencer and bus clock generator
// Assumes: srst synchronous active high; clkEn low freezes everything
// Notes: a request is taken only at the last phase of a cycle
`include "lmbs_defs.svh"

module lmbs_sequencer (
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // strap
  input  wire logic        bootstrap_input,
  // cycle request
  input  wire logic        reqValid,
  input  wire logic [20:0] reqAddr,
  input  wire logic        reqWrite,
  input  wire logic        reqRefresh,
  input  wire logic        reqParityHigh,
  input  wire logic        reqParityLow,
  output logic             reqReady,
  // read parity return
  output logic             rdValid,
  output logic             rdParityHigh,
  output logic             rdParityLow,
  // bus clocks
  output logic             local_bus_clock_a,
  output logic             local_bus_clock_b,
  // extended address / parity pins
  input  wire logic        ext_addr_parity_high_in,
  output logic             ext_addr_parity_high_out,
  output logic             ext_addr_parity_high_oe,
  input  wire logic        ext_addr_parity_low_in,
  output logic             ext_addr_parity_low_out,
  output logic             ext_addr_parity_low_oe,
  // buffer and memory strobes
  output logic             buffer_output_enable_n,
  output logic             buffer_direction,
  output logic             address_rom_output_enable_n,
  output logic             column_strobe_n,
  output logic             row_strobe_n,
  output logic             refresh_active,
  output logic             codeInRam
);
  import lmbs_pkg::*;

  lmbs_st_t st_ff;
  lmbs_st_t nxt_st;
  logic     biaHit;
  logic     epromHit;
  logic     nBia;
  logic     nEprom;
  logic [3:0] lagPhase;

  // address range decode on the registered cycle
  assign biaHit   = (st_ff.addr[20:4] == 17'h0_0000);
  assign epromHit = !st_ff.codeInRam && !biaHit &&
                    ((st_ff.addr[20:16] == `LMBS_CHAP_ROM_LO) ||
                     (st_ff.addr[20:16] == `LMBS_CHAP_ROM_HI));

  always_comb begin
    nxt_st   = st_ff;
    nBia     = 1'b0;
    nEprom   = 1'b0;
    lagPhase = 4'h0000;
    if (srst) begin
      nxt_st           = '0;
      nxt_st.state     = LMBS_IDLE;
      nxt_st.phase     = `LMBS_LAST_PHASE;
      nxt_st.codeInRam = bootstrap_input;
      nxt_st.reqReady  = 1'b1;
      nxt_st.clkA      = 1'b0;
      nxt_st.clkB      = 1'b1;
      nxt_st.bufEnN    = 1'b1;
      nxt_st.romOeN    = 1'b1;
      nxt_st.colN      = 1'b1;
      nxt_st.rowN      = 1'b1;
    end else if (clkEn) begin
      nxt_st.phase   = st_ff.phase + 4'h0001;
      nxt_st.rdValid = 1'b0;
      if (st_ff.phase == `LMBS_LAST_PHASE) begin
        // read parity is sampled as the data phase closes
        if (st_ff.state == LMBS_ACCESS && !st_ff.write) begin
          nxt_st.rdValid = 1'b1;
          nxt_st.rdParH  = ext_addr_parity_high_in;
          nxt_st.rdParL  = ext_addr_parity_low_in;
        end
        nxt_st.state = LMBS_IDLE;
        if (reqValid) begin
          nxt_st.state  = reqRefresh ? LMBS_REFRESH : LMBS_ACCESS;
          nxt_st.addr   = reqAddr;
          nxt_st.write  = reqWrite && !reqRefresh;
          nxt_st.wrParH = reqParityHigh;
          nxt_st.wrParL = reqParityLow;
        end
      end
      nxt_st.reqReady = (nxt_st.phase == `LMBS_LAST_PHASE);

      // divide by eight, second clock two sixteenths behind
      lagPhase    = nxt_st.phase - `LMBS_CLKB_LAG;
      nxt_st.clkA = !nxt_st.phase[2];
      nxt_st.clkB = !lagPhase[2];

      nBia   = (nxt_st.addr[20:4] == 17'h0_0000);
      nEprom = !nxt_st.codeInRam && !nBia &&
               ((nxt_st.addr[20:16] == `LMBS_CHAP_ROM_LO) ||
                (nxt_st.addr[20:16] == `LMBS_CHAP_ROM_HI));

      nxt_st.parHOe = 1'b0;
      nxt_st.parLOe = 1'b0;
      nxt_st.bufEnN = 1'b1;
      nxt_st.romOeN = 1'b1;
      nxt_st.colN   = 1'b1;
      nxt_st.rowN   = 1'b1;
      nxt_st.refAct = (nxt_st.state == LMBS_REFRESH);
      case (nxt_st.state)
        LMBS_ACCESS: begin
          case (nxt_st.phase[3:2])
            2'h0: begin
              nxt_st.parHOut = nxt_st.addr[`LMBS_EXT_LSB + 1];
              nxt_st.parLOut = nxt_st.addr[`LMBS_EXT_LSB + 3];
            end
            2'h1: begin
              nxt_st.parHOut = nxt_st.addr[`LMBS_EXT_LSB];
              nxt_st.parLOut = nxt_st.addr[`LMBS_EXT_LSB + 2];
            end
            default: begin
              nxt_st.parHOut = nxt_st.wrParH;
              nxt_st.parLOut = nxt_st.wrParL;
            end
          endcase
          nxt_st.parHOe = !nxt_st.phase[3] || nxt_st.write;
          nxt_st.parLOe = !nxt_st.phase[3] || nxt_st.write;
          nxt_st.bufDir = nxt_st.write;
          nxt_st.bufEnN = !(nxt_st.phase >= `LMBS_DATA_START);
          nxt_st.romOeN = !(nBia && !nxt_st.write);
          nxt_st.rowN   = !(nxt_st.phase < `LMBS_ROW_END);
          nxt_st.colN   = !((nxt_st.phase >= `LMBS_ROW_END) &&
                            (nxt_st.phase < `LMBS_COL_END) &&
                            !nBia && !nEprom);
        end
        LMBS_REFRESH: begin
          // column strobe falls one sixteenth before the row strobe
          nxt_st.colN = !(nxt_st.phase < `LMBS_COL_END);
          nxt_st.rowN = !((nxt_st.phase >= `LMBS_REF_ROW_START) &&
                          (nxt_st.phase < `LMBS_REF_ROW_END));
        end
        default: begin
          nxt_st.parHOut = 1'b0;
          nxt_st.parLOut = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    st_ff <= nxt_st;
  end

  assign reqReady                    = st_ff.reqReady;
  assign rdValid                     = st_ff.rdValid;
  assign rdParityHigh                = st_ff.rdParH;
  assign rdParityLow                 = st_ff.rdParL;
  assign local_bus_clock_a           = st_ff.clkA;
  assign local_bus_clock_b           = st_ff.clkB;
  assign ext_addr_parity_high_out    = st_ff.parHOut;
  assign ext_addr_parity_high_oe     = st_ff.parHOe;
  assign ext_addr_parity_low_out     = st_ff.parLOut;
  assign ext_addr_parity_low_oe      = st_ff.parLOe;
  assign buffer_output_enable_n      = st_ff.bufEnN;
  assign buffer_direction            = st_ff.bufDir;
  assign address_rom_output_enable_n = st_ff.romOeN;
  assign column_strobe_n             = st_ff.colN;
  assign row_strobe_n                = st_ff.rowN;
  assign refresh_active              = st_ff.refAct;
  assign codeInRam                   = st_ff.codeInRam;

  AST_HIGH_PIN: assert property (@(posedge sys_clk) disable iff (srst)
    (st_ff.state == LMBS_ACCESS && !st_ff.phase[3]) |->
      ext_addr_parity_high_oe && ext_addr_parity_high_out ==
      (st_ff.phase[2] ? st_ff.addr[16] : st_ff.addr[17]))
    else $error("high pin carries wrong extended bit");
  AST_LOW_PIN: assert property (@(posedge sys_clk) disable iff (srst)
    (st_ff.state == LMBS_ACCESS && st_ff.phase[3] && st_ff.write) |->
      ext_addr_parity_low_oe && ext_addr_parity_low_out == st_ff.wrParL)
    else $error("low pin lacks write parity");
  AST_CLK_LAG: assert property (@(posedge sys_clk) disable iff (srst)
    (clkEn && $past(clkEn) && $past(clkEn, 2) && !$past(srst, 2)) |=>
      local_bus_clock_b == $past(local_bus_clock_a, 2))
    else $error("second bus clock not a quarter behind");
  AST_CLK_DIV: assert property (@(posedge sys_clk) disable iff (srst)
    (clkEn && $rose(local_bus_clock_a)) |-> ##1 (clkEn [*7]) |=>
      $rose(local_bus_clock_a))
    else $error("bus clock period not eight clocks");
  AST_BUF_EN: assert property (@(posedge sys_clk) disable iff (srst)
    !buffer_output_enable_n |->
      st_ff.state == LMBS_ACCESS && st_ff.phase >= `LMBS_DATA_START)
    else $error("buffer enabled outside data phase");
  AST_DIR_FIRST: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(buffer_output_enable_n) |->
      $stable(buffer_direction) && buffer_direction == st_ff.write)
    else $error("direction changed with buffer enable");
  AST_ROM_OE: assert property (@(posedge sys_clk) disable iff (srst)
    st_ff.state == LMBS_ACCESS |->
      address_rom_output_enable_n == !(biaHit && !st_ff.write))
    else $error("address rom enable wrong");
  AST_COL_WINDOW: assert property (@(posedge sys_clk) disable iff (srst)
    (st_ff.state == LMBS_ACCESS && !biaHit && !epromHit &&
     st_ff.phase == `LMBS_ROW_END) |-> !column_strobe_n && row_strobe_n)
    else $error("column strobe missing after row portion");
  AST_COL_BIA: assert property (@(posedge sys_clk) disable iff (srst)
    (st_ff.state == LMBS_ACCESS && biaHit) |-> column_strobe_n)
    else $error("column strobe in address rom range");
  AST_COL_EPROM: assert property (@(posedge sys_clk) disable iff (srst)
    (st_ff.state == LMBS_ACCESS && epromHit) |-> column_strobe_n)
    else $error("column strobe in eprom map");
  AST_REF_ORDER: assert property (@(posedge sys_clk) disable iff (srst)
    (st_ff.state == LMBS_REFRESH && st_ff.phase == 4'h0000) |->
      !column_strobe_n && row_strobe_n)
    else $error("refresh column strobe not ahead of row");
  AST_ROW: assert property (@(posedge sys_clk) disable iff (srst)
    st_ff.state == LMBS_ACCESS |-> row_strobe_n == !(st_ff.phase < `LMBS_ROW_END))
    else $error("row strobe window wrong");
  AST_REFRESH: assert property (@(posedge sys_clk) disable iff (srst)
    refresh_active == (st_ff.state == LMBS_REFRESH))
    else $error("refresh active wrong");
endmodule : lmbs_sequencer

// file: lmbs_memory_model.sv
// Purpose: far side of the local memory bus: buffers, parity lines, strobe gating
// Assumes: read data phase is buffer enable low with direction low
// Notes: released lines show the inverse of their last level
module lmbs_memory_model (
  // clock
  input  wire logic clk,
  // pins from the sequencer
  input  wire logic hiOe,
  input  wire logic hiOut,
  input  wire logic loOe,
  input  wire logic loOut,
  input  wire logic bufEnN,
  input  wire logic dir,
  input  wire logic colN,
  input  wire logic refAct,
  // parity the memory returns on reads
  input  wire logic parH,
  input  wire logic parL,
  // resolved pin levels
  output logic      hiIn,
  output logic      loIn,
  output logic      colGatedN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hiLast_ff = 1'b0;
  logic loLast_ff = 1'b1;
  logic memDrv;
  assign memDrv = !bufEnN && !dir;
  assign hiIn = hiOe ? hiOut : (memDrv ? parH : !hiLast_ff);
  assign loIn = loOe ? loOut : (memDrv ? parL : !loLast_ff);
  // column strobe blocked during refresh for parts without that mode
  assign colGatedN = colN | refAct;
  always_ff @(posedge clk) begin
    hiLast_ff <= hiIn;
    loLast_ff <= loIn;
  end
endmodule : lmbs_memory_model

// file: lmbs_sequencer_bench.sv
// Purpose: self-checking bench of the local memory bus sequencer
// Assumes: inputs change 1 ns after the rising edge
// Notes: each cycle is sampled phase by phase into 16-bit masks
module lmbs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic boot = 1'b1;
  logic reqValid = 1'b0;
  logic [20:0] reqAddr = 21'h00_0000;
  logic reqWrite = 1'b0;
  logic reqRefresh = 1'b0;
  logic parH = 1'b0;
  logic parL = 1'b0;
  logic clkEn = 1'b1;
  logic reqReady, rdValid, rdParityHigh, rdParityLow, clkA, clkB, hiIn, hiOut, hiOe;
  logic loIn, loOut, loOe, bufEnN, bufDir, romOeN, colN, rowN, refAct, codeInRam, colGatedN;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  lmbs_sequencer lmbs_sequencer_i (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .bootstrap_input(boot), .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite),
    .reqRefresh(reqRefresh), .reqParityHigh(parH), .reqParityLow(parL),
    .reqReady(reqReady), .rdValid(rdValid), .rdParityHigh(rdParityHigh),
    .rdParityLow(rdParityLow), .local_bus_clock_a(clkA), .local_bus_clock_b(clkB),
    .ext_addr_parity_high_in(hiIn), .ext_addr_parity_high_out(hiOut),
    .ext_addr_parity_high_oe(hiOe), .ext_addr_parity_low_in(loIn),
    .ext_addr_parity_low_out(loOut), .ext_addr_parity_low_oe(loOe),
    .buffer_output_enable_n(bufEnN), .buffer_direction(bufDir),
    .address_rom_output_enable_n(romOeN), .column_strobe_n(colN), .row_strobe_n(rowN),
    .refresh_active(refAct), .codeInRam(codeInRam));
  lmbs_memory_model lmbs_memory_model_i (.clk(sys_clk), .hiOe(hiOe), .hiOut(hiOut),
    .loOe(loOe), .loOut(loOut), .bufEnN(bufEnN), .dir(bufDir), .colN(colN),
    .refAct(refAct), .parH(parH), .parL(parL), .hiIn(hiIn), .loIn(loIn),
    .colGatedN(colGatedN));
  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, input logic e, input string m);
    chk16({15'h0000, g}, {15'h0000, e}, m);
  endtask : chk1
  // one memory cycle: request at phase 15, then sample all sixteen phases
  task automatic cyc(input logic [20:0] a, input logic wr, input logic rf,
                     input logic ph, input logic pl);
    logic [15:0] col, row, be, rom, ra, ho, hv, lo, lv, ca, cb, dr, eo, cg, rr;
    logic romHit, epHit;
    int n;
    romHit = (a[20:4] == 17'h0_0000) && !rf;
    epHit = !boot && !romHit && (a[20:16] == 5'h00 || a[20:16] == 5'h1F);
    eo = rf ? 16'h0000 : (wr ? 16'hFFFF : 16'h00FF);
    n = 0;
    while (reqReady !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    reqValid = 1'b1;
    reqAddr = a;
    reqWrite = wr;
    reqRefresh = rf;
    parH = ph;
    parL = pl;
    @(posedge sys_clk);
    #1;
    reqValid = 1'b0;
    for (int p = 0; p < 16; p++) begin
      {col[p], row[p], be[p], rom[p], ra[p]} = {!colN, !rowN, !bufEnN, !romOeN, refAct};
      {cg[p], rr[p]} = {!colGatedN, reqReady};
      {ho[p], hv[p], lo[p], lv[p], ca[p], cb[p], dr[p]} = {hiOe, hiOut, loOe, loOut,
                                                          clkA, clkB, bufDir};
      @(posedge sys_clk);
      #1;
    end
    chk16(row, rf ? 16'h003E : 16'h001F, "row strobe");
    chk16(col, rf ? 16'h00FF : ((romHit || epHit) ? 16'h0000 : 16'h00E0), "col");
    chk16(cg, (rf || romHit || epHit) ? 16'h0000 : 16'h00E0, "gated col");
    chk16(rr, 16'h8000, "ready");
    chk16(ra, rf ? 16'hFFFF : 16'h0000, "refresh active");
    chk16(be, rf ? 16'h0000 : 16'hFF00, "buffer enable");
    chk16(rom, (romHit && !wr) ? 16'hFFFF : 16'h0000, "rom enable");
    chk16(ca, 16'h0F0F, "bus clock a");
    chk16(cb, 16'h3C3C, "bus clock b");
    if (!rf) chk16(dr, wr ? 16'hFFFF : 16'h0000, "direction");
    chk16(ho, eo, "high pin oe");
    chk16(lo, eo, "low pin oe");
    chk16(hv & eo, {{8{ph}}, {4{a[16]}}, {4{a[17]}}} & eo, "high pin value");
    chk16(lv & eo, {{8{pl}}, {4{a[18]}}, {4{a[19]}}} & eo, "low pin value");
    if (!rf && !wr) begin
      chk1(rdValid, 1'b1, "read valid");
      chk1(rdParityHigh, ph, "read parity high");
      chk1(rdParityLow, pl, "read parity low");
    end else begin
      chk1(rdValid, 1'b0, "no read valid");
    end
  endtask : cyc
  task automatic do_reset(input logic b);
    srst = 1'b1;
    boot = b;
    repeat (12) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    chk1(codeInRam, b, "strap");
    chk1(colN & rowN & bufEnN & romOeN, 1'b1, "strobes idle");
  endtask : do_reset
  task automatic t_dram;
    cyc(21'h05_2345, 1'b0, 1'b0, 1'b1, 1'b0);
    cyc(21'h0A_1234, 1'b1, 1'b0, 1'b0, 1'b1);
    cyc(21'h1F_0000, 1'b0, 1'b0, 1'b0, 1'b1);
  endtask : t_dram
  task automatic t_refresh;
    cyc(21'h10_0000, 1'b0, 1'b1, 1'b0, 1'b0);
    cyc(21'h03_0001, 1'b0, 1'b0, 1'b1, 1'b1);
  endtask : t_refresh
  task automatic t_rom;
    cyc(21'h00_000F, 1'b0, 1'b0, 1'b1, 1'b1);
    cyc(21'h00_0000, 1'b1, 1'b0, 1'b0, 1'b0);
    cyc(21'h00_0010, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask : t_rom
  task automatic t_eprom;
    cyc(21'h00_0010, 1'b0, 1'b0, 1'b1, 1'b0);
    cyc(21'h1F_FFFF, 1'b1, 1'b0, 1'b0, 1'b1);
    cyc(21'h1E_FFFF, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask : t_eprom
  // enable low: sixteen outputs hold (the read parity outputs are not checked), then the next cycle runs normally
  task automatic t_freeze;
    logic [15:0] snap, held;
    while (reqReady !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    snap = {clkA, clkB, colN, rowN, bufEnN, romOeN, refAct, hiOe, hiOut, loOe, loOut, bufDir,
            reqReady, rdValid, codeInRam, colGatedN};
    clkEn = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    held = {clkA, clkB, colN, rowN, bufEnN, romOeN, refAct, hiOe, hiOut, loOe, loOut, bufDir,
            reqReady, rdValid, codeInRam, colGatedN};
    chk16(held, snap, "frozen outputs");
    clkEn = 1'b1;
    cyc(21'h02_4680, 1'b1, 1'b0, 1'b1, 1'b0);
  endtask : t_freeze
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    do_reset(1'b1);
    t_dram();
    t_refresh();
    t_rom();
    t_freeze();
    do_reset(1'b0);
    t_eprom();
    end_sim();
  end
endmodule : lmbs_sequencer_bench
